// *** shared/epwm_pkg.sv ***
/*
 * Constants and types for the enhanced pulse-width output stage.
 * Assumes a single system clock; register indexes are word-free small addresses on a plain port.
 */
`default_nettype none

package epwm_pkg;

    // Register indexes on the plain register port
    localparam logic [3:0] EPWM_REG_MODE = 4'h0;
    localparam logic [3:0] EPWM_REG_DUTY_HI = 4'h1;
    localparam logic [3:0] EPWM_REG_PERIOD = 4'h2;
    localparam logic [3:0] EPWM_REG_TIMER_CTL = 4'h3;
    localparam logic [3:0] EPWM_REG_DEADBAND = 4'h4;
    localparam logic [3:0] EPWM_REG_STEER = 4'h5;
    localparam logic [3:0] EPWM_REG_PIN_DIR = 4'h6;
    localparam logic [3:0] EPWM_REG_TIMER = 4'h7;
    localparam logic [3:0] EPWM_REG_SHADOW = 4'h8;

    // Field positions inside the mode control register
    localparam int EPWM_CFG_HI = 7;
    localparam int EPWM_CFG_LO = 6;
    localparam int EPWM_DLOW_HI = 5;
    localparam int EPWM_DLOW_LO = 4;
    localparam int EPWM_CCP_HI = 3;
    localparam int EPWM_CCP_LO = 0;
    // Field positions inside the timer control register
    localparam int EPWM_TON_BIT = 2;
    localparam int EPWM_PSC_HI = 1;
    localparam int EPWM_PSC_LO = 0;

    // Values after reset
    localparam logic [7:0] EPWM_RST_REG = 8'h00;
    localparam logic [3:0] EPWM_RST_PIN_DIR = 4'hF;

    // Output configuration codes
    localparam logic [1:0] EPWM_CFG_SINGLE = 2'h0;
    localparam logic [1:0] EPWM_CFG_FWD = 2'h1;
    localparam logic [1:0] EPWM_CFG_HALF = 2'h2;
    localparam logic [1:0] EPWM_CFG_REV = 2'h3;
    // Upper mode bits that select the enhanced pulse mode
    localparam logic [1:0] EPWM_CCP_PWM = 2'h3;

    // Prescaler codes and their terminal counts
    localparam logic [1:0] EPWM_PSC_1 = 2'h0;
    localparam logic [1:0] EPWM_PSC_4 = 2'h1;
    localparam logic [3:0] EPWM_PSC_LIM_1 = 4'h0;
    localparam logic [3:0] EPWM_PSC_LIM_4 = 4'h3;
    localparam logic [3:0] EPWM_PSC_LIM_16 = 4'hF;

    // Timing: one instruction cycle is four system clocks
    localparam int EPWM_SYS_CLK_NS = 40;
    localparam int EPWM_CLKS_PER_INSTR = 4;
    localparam logic [1:0] EPWM_PHASE_LAST = 2'(EPWM_CLKS_PER_INSTR - 1);

    // Pin masks in D,C,B,A order
    localparam logic [3:0] EPWM_MASK_HALF = 4'h3;
    localparam logic [3:0] EPWM_MASK_FULL = 4'hF;

    // Pin bundle handed to the port logic
    typedef struct packed {
        logic [3:0] level;
        logic [3:0] drive_en;
        logic [3:0] owned;
    } epwm_pins_t;

endpackage

`default_nettype wire

// *** core/epwm_core.sv ***
/*
 * Enhanced pulse-width output stage: timebase, duty double buffer, single / half-bridge /
 * full-bridge output steering, dead-band and polarity, plus its register file.
 * Assumes a same-clock register master with one-cycle strobes and the port logic
 * that resolves each pin from the owned / drive-enable / level bundle.
 */
// Added by the designer: the register offsets and the address-and-strobe port.
// Operation
// - Pulse frequency is derived from system clock; scales with it.
// - Reset returns all registers to reset values and pins to input.
// - Up to ten-bit duty resolution on up to four output pins.
// - Two-bit config selects single, half-bridge, forward or reverse full-bridge.
// - Single configuration enables only pins selected by steering bits.
// - Half-bridge drives modulated signal on A and its complement on B.
// - Half-bridge delays each rising transition by dead-band instruction cycles.
// - Dead-band longer than active time keeps that output inactive whole period.
// - Forward: A active, D modulated, B and C inactive.
// - Reverse: C active, B modulated, A and D inactive.
// - Polarity of the pins follows the low mode bits.
// - After enabling, output waits for a new period to start.
// - Mode register written to zero releases all pins to port logic.
// - Pins unused by the configuration stay with their port functions.
// - Ten-bit timebase is timer plus two low bits from phase or prescaler.
// - Period end clears timer, sets output unless zero duty, latches duty.
// - Active portion ends when timebase equals latched duty.
// - Duty is eight high bits plus two low bits.
// - At 1:1 prescale the low timebase bits come from clock phase.
`timescale 1ns/100ps
`default_nettype none

module epwm_core
    import epwm_pkg::*;
(
    // Clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    // Register port
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Pin bundle
    output epwm_pins_t o_pins
);

    // Prescaler terminal count per code, used by the counter and the timebase
    function automatic logic [3:0] psc_limit(input logic [1:0] code);
        begin
            if (code == EPWM_PSC_1)
                psc_limit = EPWM_PSC_LIM_1;
            else if (code == EPWM_PSC_4)
                psc_limit = EPWM_PSC_LIM_4;
            else
                psc_limit = EPWM_PSC_LIM_16;
        end
    endfunction

    // Software registers
    logic [7:0] mode_r;
    logic [7:0] duty_hi_r;
    logic [7:0] period_r;
    logic [2:0] tctl_r;
    logic [6:0] dband_r;
    logic [3:0] steer_r;
    logic [3:0] pin_dir_r;
    // Timebase and duty state
    logic [1:0] phase_r;
    logic [3:0] psc_r;
    logic [7:0] timer_r;
    logic [9:0] shadow_r;
    logic pulse_r;
    logic started_r;
    // Dead-band state
    logic [8:0] db_cnt_r;
    logic prev_a_r;
    logic prev_b_r;

    // Field decode
    wire [1:0] cfg = mode_r[EPWM_CFG_HI:EPWM_CFG_LO];
    wire [1:0] ccp = mode_r[EPWM_CCP_LO + 1:EPWM_CCP_LO]; // Polarity pair only; upper bits gate the mode
    wire pwm_on = (mode_r[EPWM_CCP_HI:EPWM_CCP_HI - 1] == EPWM_CCP_PWM);
    wire [1:0] psc_code = tctl_r[EPWM_PSC_HI:EPWM_PSC_LO];
    wire tmr_on = tctl_r[EPWM_TON_BIT];
    wire [9:0] duty_buf = {duty_hi_r, mode_r[EPWM_DLOW_HI:EPWM_DLOW_LO]};

    // Register write strobes
    wire wr_mode = i_wr & (i_addr == EPWM_REG_MODE);
    wire wr_duty = i_wr & (i_addr == EPWM_REG_DUTY_HI);
    wire wr_per = i_wr & (i_addr == EPWM_REG_PERIOD);
    wire wr_tctl = i_wr & (i_addr == EPWM_REG_TIMER_CTL);
    wire wr_db = i_wr & (i_addr == EPWM_REG_DEADBAND);
    wire wr_steer = i_wr & (i_addr == EPWM_REG_STEER);
    wire wr_dir = i_wr & (i_addr == EPWM_REG_PIN_DIR);

    // Timebase steps: everything derives from the system clock phase
    wire [3:0] psc_lim = psc_limit(psc_code);
    wire instr_tick = (phase_r == EPWM_PHASE_LAST);
    wire psc_wrap = (psc_r >= psc_lim); // A prescale change mid-count must not run the counter round
    wire tmr_inc = tmr_on & instr_tick & psc_wrap;
    wire period_end = tmr_inc & (timer_r == period_r);

    // Two low timebase bits: clock phase at 1:1, otherwise prescaler bits
    wire [1:0] low2 = (psc_code == EPWM_PSC_1) ? phase_r :
        ((psc_code == EPWM_PSC_4) ? psc_r[1:0] : psc_r[3:2]);
    wire [9:0] tbase = {timer_r, low2};
    wire duty_match = (tbase == shadow_r);

    // Phase, prescaler and timer
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            phase_r <= 2'h0;
            psc_r <= 4'h0;
            timer_r <= 8'h00;
        end
        else if (i_clk_en)
        begin
            phase_r <= phase_r + 2'h1;
            if (tmr_on & instr_tick)
                psc_r <= psc_wrap ? 4'h0 : psc_r + 4'h1;
            if (period_end)
                timer_r <= 8'h00;
            else if (tmr_inc)
                timer_r <= timer_r + 8'h01;
        end
    end

    // Duty double buffer and raw pulse; a new period wins over a duty match
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            shadow_r <= 10'h000;
            pulse_r <= 1'b0;
        end
        else if (i_clk_en)
        begin
            if (period_end)
            begin
                shadow_r <= duty_buf;
                pulse_r <= (duty_buf != 10'h000);
            end
            else if (duty_match)
                pulse_r <= 1'b0;
        end
    end

    // First enable waits for a period boundary, so no partial first pulse escapes
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            started_r <= 1'b0;
        else if (i_clk_en)
        begin
            if (!pwm_on)
                started_r <= 1'b0;
            else if (period_end)
                started_r <= 1'b1;
        end
    end

    // Logical (active = 1) half-bridge sources before dead-band
    // Pulse drops in the first cycle of a duty match, so the pins see exactly the duty width
    wire pulse_eff = pulse_r & ~duty_match;
    wire act = pulse_eff & started_r;
    wire hb_mode = (cfg == EPWM_CFG_HALF);
    wire raw_a = hb_mode & started_r & pulse_eff;
    wire raw_b = hb_mode & started_r & ~pulse_eff;
    wire rise_a = raw_a & ~prev_a_r;
    wire rise_b = raw_b & ~prev_b_r;
    wire db_zero = (dband_r == 7'h00);
    // The rise cycle itself counts as the first clock of the delay
    wire [8:0] db_load = db_zero ? 9'h000 : ({dband_r, 2'h0} - 9'h001);

    // One shared counter is enough: A and B never rise in the same clock
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            db_cnt_r <= 9'h000;
            prev_a_r <= 1'b0;
            prev_b_r <= 1'b0;
        end
        else if (i_clk_en)
        begin
            prev_a_r <= raw_a;
            prev_b_r <= raw_b;
            if (rise_a | rise_b)
                db_cnt_r <= db_load;
            else if (db_cnt_r != 9'h000)
                db_cnt_r <= db_cnt_r - 9'h001;
        end
    end

    // An output only goes active once the delay has run out while its source still holds
    wire db_done_a = rise_a ? db_zero : (db_cnt_r == 9'h000);
    wire db_done_b = rise_b ? db_zero : (db_cnt_r == 9'h000);
    wire del_a = raw_a & db_done_a;
    wire del_b = raw_b & db_done_b;

    // Logical output per configuration, D,C,B,A order
    wire [3:0] lg_single = {4{act}} & steer_r;
    wire [3:0] lg_half = {2'h0, del_b, del_a};
    wire [3:0] lg_fwd = {act, 1'b0, 1'b0, started_r};
    wire [3:0] lg_rev = {1'b0, started_r, act, 1'b0};
    wire [3:0] lg_sel = (cfg == EPWM_CFG_SINGLE) ? lg_single :
        (cfg == EPWM_CFG_HALF) ? lg_half :
        (cfg == EPWM_CFG_FWD) ? lg_fwd : lg_rev;

    // Polarity: bit 1 inverts A/C, bit 0 inverts B/D
    wire [3:0] inv_mask = {ccp[0], ccp[1], ccp[0], ccp[1]};
    wire [3:0] level_nxt = lg_sel ^ inv_mask;

    // Pin ownership: unused pins stay with the port logic
    wire [3:0] use_mask = (cfg == EPWM_CFG_SINGLE) ? steer_r :
        (cfg == EPWM_CFG_HALF) ? EPWM_MASK_HALF : EPWM_MASK_FULL;
    wire [3:0] own_nxt = pwm_on ? use_mask : 4'h0;
    wire [3:0] oe_nxt = own_nxt & ~pin_dir_r;

    // Registered pin bundle, inputs (not driven) straight out of reset
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            o_pins <= '0;
        else if (i_clk_en)
        begin
            o_pins.level <= level_nxt & own_nxt;
            o_pins.drive_en <= oe_nxt;
            o_pins.owned <= own_nxt;
        end
    end

    // Software register file; all controls reset to defined values
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            mode_r <= EPWM_RST_REG;
            duty_hi_r <= EPWM_RST_REG;
            period_r <= EPWM_RST_REG;
            tctl_r <= EPWM_RST_REG[2:0];
            dband_r <= EPWM_RST_REG[6:0];
            steer_r <= EPWM_RST_REG[3:0];
            pin_dir_r <= EPWM_RST_PIN_DIR;
        end
        else if (i_clk_en)
        begin
            if (wr_mode)
                mode_r <= i_wdata;
            if (wr_duty)
                duty_hi_r <= i_wdata;
            if (wr_per)
                period_r <= i_wdata;
            if (wr_tctl)
                tctl_r <= i_wdata[2:0];
            if (wr_db)
                dband_r <= i_wdata[6:0];
            if (wr_steer)
                steer_r <= i_wdata[3:0];
            if (wr_dir)
                pin_dir_r <= i_wdata[3:0];
        end
    end

    // Read mux; unmapped addresses and reserved bits read zero
    logic [7:0] rd_mux;
    always_comb
    begin
        case (i_addr)
            EPWM_REG_MODE: rd_mux = mode_r;
            EPWM_REG_DUTY_HI: rd_mux = duty_hi_r;
            EPWM_REG_PERIOD: rd_mux = period_r;
            EPWM_REG_TIMER_CTL: rd_mux = {5'h00, tctl_r};
            EPWM_REG_DEADBAND: rd_mux = {1'b0, dband_r};
            EPWM_REG_STEER: rd_mux = {4'h0, steer_r};
            EPWM_REG_PIN_DIR: rd_mux = {4'h0, pin_dir_r};
            EPWM_REG_TIMER: rd_mux = timer_r;
            EPWM_REG_SHADOW: rd_mux = shadow_r[9:2];
            default: rd_mux = 8'h00;
        endcase
    end

    // Read data stands in the cycle after the strobe only
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            o_rdata <= 8'h00;
        else if (i_clk_en)
            o_rdata <= i_rd ? rd_mux : 8'h00;
    end

    // Checks
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_period_end;
        i_clk_en && period_end;
    endsequence

    sequence s_a_rise_delayed;
        i_clk_en && rise_a && !db_zero;
    endsequence

    chk_timer_wrap: assert property (
        s_period_end |=> timer_r == 8'h00)
        else $error("timer not cleared at period end");

    chk_shadow_load: assert property (
        s_period_end |=> shadow_r == $past(duty_buf) && pulse_r == ($past(duty_buf) != 10'h000))
        else $error("duty shadow or pulse wrong at period start");

    chk_duty_end: assert property (
        i_clk_en && duty_match && !period_end |=> !pulse_r)
        else $error("pulse not ended on duty match");

    chk_no_partial: assert property (
        i_clk_en && !started_r && !period_end |=> o_pins.level == ($past(inv_mask) & $past(own_nxt)))
        else $error("output active before first period");

    chk_release_pins: assert property (
        i_clk_en && wr_mode && i_wdata == 8'h00 ##1 i_clk_en && !i_wr |=> o_pins.owned == 4'h0)
        else $error("pins not released after mode cleared");

    chk_half_unused: assert property (
        i_clk_en && hb_mode && pwm_on |=> o_pins.owned[3:2] == 2'h0)
        else $error("half-bridge drives unused pins");

    chk_drive_dir: assert property (
        (o_pins.drive_en & ~o_pins.owned) == 4'h0)
        else $error("drive enable without ownership");

    chk_deadband_hold: assert property (
        s_a_rise_delayed |-> !del_a ##1 (i_clk_en && raw_a) [*3] |-> !del_a)
        else $error("half-bridge rose inside dead-band");

    chk_fwd_pins: assert property (
        i_clk_en && pwm_on && cfg == EPWM_CFG_FWD && started_r && !wr_mode && !i_wr
        |=> (o_pins.level[2:1] ^ $past(inv_mask[2:1])) == 2'h0)
        else $error("forward mode drives B or C active");

    chk_phase_low: assert property (
        psc_code == EPWM_PSC_1 |-> tbase[1:0] == phase_r)
        else $error("low timebase bits not from clock phase");

    chk_read_once: assert property (
        i_clk_en && !i_rd |=> o_rdata == 8'h00)
        else $error("read data outside its cycle");

    chk_freeze_state: assert property (
        !i_clk_en |=> $stable(o_pins) && $stable(timer_r) && $stable(shadow_r))
        else $error("state moved while clock enable low");

endmodule

`default_nettype wire

// *** sim/epwm_bridge_model.sv ***
/*
 * Power-switch bridge model that sits on the generator's pin bundle.
 * Assumes the bundle is registered on i_sys_clk; undriven pads have no pull.
 */
`timescale 1ns/100ps
`default_nettype none

module epwm_bridge_model
    import epwm_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Pin bundle from the generator
    input wire epwm_pins_t i_pins,
    // Pad levels and shoot-through cycle count
    output logic [3:0] o_pad,
    output logic [15:0] o_overlap
);
    logic [3:0] float_r;

    // Undriven pads wander so a stale level is never mistaken for output
    assign o_pad = (i_pins.drive_en & i_pins.level) | (~i_pins.drive_en & float_r);

    // High and low switch of leg A/B both on means shoot-through
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            float_r <= 4'h5;
            o_overlap <= 16'h0000;
        end
        else
        begin
            float_r <= ~float_r;
            o_overlap <= o_overlap + 16'(o_pad[0] & o_pad[1] & (&i_pins.drive_en[1:0]));
        end
    end
endmodule

`default_nettype wire

// *** sim/tb.sv ***
/*
 * Self-checking bench for the enhanced pulse-width stage.
 * Assumes the register map and timing of the core; steady-state widths are counted per period.
 */
`timescale 1ns/100ps
`default_nettype none

module tb;
    import epwm_pkg::*;
    localparam int PER_LIM = 7;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_clk_en = 1'b1;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] o_rdata;
    epwm_pins_t o_pins;
    logic [3:0] pad;
    logic [15:0] overlap;
    logic [15:0] ov0;
    logic [15:0] seed = 16'h52D6;
    logic [7:0] v;
    logic [7:0] v1;
    logic [3:0] dir_set = 4'hF;
    int err_count = 0;
    int check_count = 0;
    int hi_cnt [4];
    int d;

    always #20 i_sys_clk = ~i_sys_clk;

    epwm_core DUT (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_en(i_clk_en), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pins(o_pins));
    epwm_bridge_model bridge (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_pins(o_pins), .o_pad(pad),
        .o_overlap(overlap));

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        if (err_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Random draw in lo .. lo+span-1
    function automatic int draw(input int lo, input int span);
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return lo + int'(seed) % span;
    endfunction

    task automatic wr(input logic [3:0] a, input logic [7:0] data);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= data;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] r);
        @(posedge i_sys_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        r = o_rdata;
    endtask

    // Expected high cycles on a pad over one period, polarity included
    function automatic int exp_high(input int pin, input logic [1:0] cfg, input logic [3:0] ccp,
        input int w, input int dbc, input int p, input logic [3:0] steer);
        int a;
        logic inv;
        inv = (pin % 2 == 0) ? ccp[1] : ccp[0];
        case (cfg)
            EPWM_CFG_SINGLE: a = steer[pin] ? w : 0;
            EPWM_CFG_HALF: a = (pin == 0) ? ((w > dbc) ? w - dbc : 0) : ((p - w > dbc) ? p - w - dbc : 0);
            EPWM_CFG_FWD: a = (pin == 0) ? p : (pin == 3) ? w : 0;
            default: a = (pin == 2) ? p : (pin == 1) ? w : 0;
        endcase
        return inv ? p - a : a;
    endfunction

    task automatic count_win(input int n);
        for (int i = 0; i < 4; i++)
            hi_cnt[i] = 0;
        repeat (n)
        begin
            @(posedge i_sys_clk);
            #1;
            for (int i = 0; i < 4; i++)
                hi_cnt[i] += (pad[i] === 1'b1) ? 1 : 0;
        end
    endtask

    // Program one output configuration, let the duty settle, then count one period
    task automatic run_cfg(input logic [1:0] cfg, input logic [3:0] ccp, input int dty, input int dbq,
        input logic [3:0] steer, input logic [1:0] psc);
        int p;
        int sc;
        logic [3:0] own;
        sc = (psc == EPWM_PSC_4) ? 4 : 1;
        p = (PER_LIM + 1) * EPWM_CLKS_PER_INSTR * sc;
        own = (cfg == EPWM_CFG_SINGLE) ? steer : (cfg == EPWM_CFG_HALF) ? EPWM_MASK_HALF : EPWM_MASK_FULL;
        wr(EPWM_REG_TIMER_CTL, {5'h01, psc});
        wr(EPWM_REG_DEADBAND, 8'(dbq));
        wr(EPWM_REG_STEER, {4'h0, steer});
        wr(EPWM_REG_DUTY_HI, 8'(dty >> 2));
        wr(EPWM_REG_MODE, {cfg, 2'(dty), ccp});
        repeat (3 * p) @(posedge i_sys_clk);
        ov0 = overlap;
        count_win(p);
        check("owned", 16'(o_pins.owned), 16'(own));
        for (int i = 0; i < 4; i++)
            if (own[i] && !dir_set[i])
                check("active", 16'(hi_cnt[i]), 16'(exp_high(i, cfg, ccp, dty * sc, dbq * 4, p, steer)));
            else if (own[i])
                check("float", 16'(hi_cnt[i]), 16'(p / 2));
        if (cfg == EPWM_CFG_HALF && ccp[1:0] == 2'h0)
            check("overlap", overlap - ov0, 16'h0000);
        rd(EPWM_REG_SHADOW, v);
        check("shadow", 16'(v), 16'(dty >> 2));
    endtask

    // Watchdog well beyond the few thousand cycles the sequence needs
    initial
    begin
        repeat (40000) @(posedge i_sys_clk);
        err_count++;
        results();
    end

    initial
    begin
        repeat (4) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        check("pins", 16'(o_pins), 16'h0000);
        for (int a = 0; a < 10; a++)
        begin
            rd((a == 9) ? 4'hF : 4'(a), v);
            check("reset", 16'(v), (a == 6) ? 16'(EPWM_RST_PIN_DIR) : 16'h0000);
        end
        for (int k = 0; k < 3; k++)
        begin
            d = draw(0, 256);
            wr(EPWM_REG_DEADBAND, 8'(d));
            rd(EPWM_REG_DEADBAND, v);
            check("deadband", 16'(v), 16'(d & 8'h7F));
        end
        wr(EPWM_REG_PERIOD, 8'(PER_LIM));
        wr(EPWM_REG_PIN_DIR, 8'h00);
        dir_set = 4'h0;
        // Forward mode with the timer stopped: pin A must wait for a period start
        wr(EPWM_REG_MODE, 8'h4C);
        repeat (8) @(posedge i_sys_clk);
        check("no partial", 16'(o_pins.level), 16'h0000);
        run_cfg(EPWM_CFG_SINGLE, 4'hC, 0, 0, 4'hF, EPWM_PSC_1);
        for (int k = 0; k < 2; k++)
        begin
            d = draw(1, 31);
            run_cfg(EPWM_CFG_SINGLE, 4'hC, d, 0, 4'(k + 5), EPWM_PSC_1);
            d = draw(9, 14);
            run_cfg(EPWM_CFG_HALF, 4'hC, d, 2, 4'h0, EPWM_PSC_1);
            run_cfg(EPWM_CFG_FWD, 4'hC, d, 0, 4'h0, EPWM_PSC_1);
            run_cfg(EPWM_CFG_REV, 4'hC, d, 0, 4'h0, EPWM_PSC_1);
        end
        run_cfg(EPWM_CFG_HALF, 4'hC, 13, 10, 4'h0, EPWM_PSC_1);
        run_cfg(EPWM_CFG_SINGLE, 4'hC, 21, 0, 4'h1, EPWM_PSC_4);
        run_cfg(EPWM_CFG_FWD, 4'hE, 14, 0, 4'h0, EPWM_PSC_1);
        run_cfg(EPWM_CFG_HALF, 4'hD, 18, 1, 4'h0, EPWM_PSC_1);
        wr(EPWM_REG_SHADOW, 8'h5A);
        rd(EPWM_REG_SHADOW, v);
        check("shadow ro", 16'(v), 16'(18 >> 2));
        wr(EPWM_REG_PIN_DIR, 8'h0A);
        dir_set = 4'hA;
        run_cfg(EPWM_CFG_SINGLE, 4'hC, 7, 0, 4'hF, EPWM_PSC_1);
        check("drive", 16'(o_pins.drive_en), 16'h0005);
        wr(EPWM_REG_MODE, 8'h00);
        repeat (2) @(posedge i_sys_clk);
        check("release", 16'(o_pins.owned | o_pins.drive_en), 16'h0000);
        run_cfg(EPWM_CFG_FWD, 4'hC, 9, 0, 4'h0, EPWM_PSC_1);
        // Sixteen frozen clocks: the timer may move one step at most across the two reads
        rd(EPWM_REG_TIMER, v);
        @(posedge i_sys_clk);
        i_clk_en <= 1'b0;
        repeat (16) @(posedge i_sys_clk);
        i_clk_en <= 1'b1;
        rd(EPWM_REG_TIMER, v1);
        check("freeze", 16'(((v1 - v) & 8'h07) > 8'h01), 16'h0000);
        @(posedge i_sys_clk);
        i_rst <= 1'b1;
        @(posedge i_sys_clk);
        i_rst <= 1'b0;
        #1;
        check("pins rst", 16'(o_pins), 16'h0000);
        rd(EPWM_REG_PIN_DIR, v);
        check("dir rst", 16'(v), 16'(EPWM_RST_PIN_DIR));
        results();
    end
endmodule

`default_nettype wire
